// >>> pins_pkg.sv
package pins_pkg;

  // Mode-select strap codes
  localparam logic [1:0] MODE_BSCAN = 2'h0;
  localparam logic [1:0] MODE_EMU = 2'h3;
  localparam logic [1:0] MODE_STRAP_DEFAULT = MODE_EMU;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Register offsets (word addresses)
  localparam logic [3:0] ADDR_IER = 4'h0;
  localparam logic [3:0] ADDR_POL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_GPIO_DIR = 4'h4;
  localparam logic [3:0] ADDR_GPIO_OUT = 4'h5;
  localparam logic [3:0] ADDR_GPIO_IN = 4'h6;
  localparam logic [3:0] ADDR_CONFIG = 4'h7;
  localparam logic [3:0] ADDR_MODE = 4'h8;

  // Field positions
  localparam int IER_LO = 4;
  localparam int IER_HI = 7;
  localparam int POL_LO = 0;
  localparam int POL_HI = 3;
  localparam int ST_NMI = 4;
  localparam int CFG_GP15_GPIO = 0;
  localparam int CFG_GPIO_FIFTEEN_OR_PCI_RESET = 1;
  localparam int GP15_BIT = 4;

  // Reset values
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [3:0] POL_RESET = 4'h0;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [4:0] DIR_RESET = 5'h00;
  localparam logic [4:0] OUT_RESET = 5'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;

  typedef enum logic [1:0] {
    OP_BSCAN = 2'b00,
    OP_RSVD_A = 2'b01,
    OP_RSVD_B = 2'b10,
    OP_EMU = 2'b11
  } op_mode_e;

endpackage : pins_pkg

// >>> mode_pins_and_ext_interrupts.sv
`timescale 1ns/1ps
`default_nettype none

module mode_pins_and_ext_interrupts
  import pins_pkg::*;
#(
  parameter int NUM_EXT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps and interrupt pins
  input wire logic mode_select_bit_high,
  input wire logic mode_select_bit_low,
  input wire logic nmi_pin,
  // Shared pins 7..4 and pin 15
  input wire logic [NUM_EXT-1:0] shared_pin_in,
  output logic [NUM_EXT-1:0] shared_pin_out,
  output logic [NUM_EXT-1:0] shared_pin_oe,
  input wire logic gpio_fifteen_or_pci_reset_in,
  output logic gpio_fifteen_or_pci_reset_out,
  output logic gpio_fifteen_or_pci_reset_oe,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Core side
  output logic nmi_pulse,
  output logic [NUM_EXT-1:0] ext_irq_pulse,
  output logic pci_reset_n,
  output logic boundary_scan_mode,
  output logic emulation_mode,
  output logic mode_reserved,
  output logic core_run_enable,
  output logic irq
);

  typedef struct packed {
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;
    logic [1:0] mode_latched;
    logic strap_taken;
    logic [1:0] strap_wait;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic [NUM_EXT-1:0] pin_meta;
    logic [NUM_EXT-1:0] pin_sync;
    logic [NUM_EXT-1:0] pin_prev;
    logic g15_meta;
    logic g15_sync;
    logic [7:0] interrupt_enable_bits;
    logic [3:0] pol;
    logic [4:0] status;
    logic [4:0] mask;
    logic [4:0] dir;
    logic [4:0] dout;
    logic [1:0] cfg;
    logic nmi_p;
    logic [NUM_EXT-1:0] ext_p;
    logic [31:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic logic edge_hit(input logic cur, input logic prev, input logic falling);
    edge_hit = falling ? (prev & ~cur) : (cur & ~prev);
  endfunction : edge_hit

  logic [NUM_EXT-1:0] ext_event;
  logic nmi_event;
  logic [4:0] set_bits;
  logic [4:0] clr_bits;
  op_mode_e op_mode;

  assign op_mode = op_mode_e'(state_reg.mode_latched);

  always_comb begin
    state_next = state_reg;
    // Two-flop synchronisers; first stage read only by the second
    state_next.mode_meta = {mode_select_bit_high, mode_select_bit_low};
    state_next.mode_sync = state_reg.mode_meta;
    state_next.nmi_meta = nmi_pin;
    state_next.nmi_sync = state_reg.nmi_meta;
    state_next.nmi_prev = state_reg.nmi_sync;
    state_next.pin_meta = shared_pin_in;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.pin_prev = state_reg.pin_sync;
    state_next.g15_meta = gpio_fifteen_or_pci_reset_in;
    state_next.g15_sync = state_reg.g15_meta;
    // Strap caught once, only after both flops hold the pin level, not reset zeros
    if (!state_reg.strap_taken) begin
      if (state_reg.strap_wait == STRAP_SETTLE) begin
        state_next.mode_latched = state_reg.mode_sync;
        state_next.strap_taken = 1'b1;
      end else begin
        state_next.strap_wait = state_reg.strap_wait + 2'h1;
      end
    end
    nmi_event = edge_hit(state_reg.nmi_sync, state_reg.nmi_prev, 1'b0);
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_event[i] = state_reg.interrupt_enable_bits[IER_LO + i]
          & ~state_reg.dir[i]
          & edge_hit(state_reg.pin_sync[i], state_reg.pin_prev[i],
                     state_reg.pol[POL_LO + i]);
    end
    state_next.nmi_p = nmi_event;
    state_next.ext_p = ext_event;
    set_bits = {nmi_event, ext_event};
    clr_bits = 5'h00;
    if (wr_en) begin
      case (addr)
        ADDR_IER: state_next.interrupt_enable_bits = wdata[7:0];
        ADDR_POL: state_next.pol = wdata[POL_HI:POL_LO];
        ADDR_STATUS: clr_bits = wdata[4:0];
        ADDR_MASK: state_next.mask = wdata[4:0];
        ADDR_GPIO_DIR: state_next.dir = wdata[4:0];
        ADDR_GPIO_OUT: state_next.dout = wdata[4:0];
        ADDR_CONFIG: begin
          // Pin 15 functions are exclusive; PCI reset wins if both set
          state_next.cfg = wdata[1:0];
          if (wdata[CFG_GPIO_FIFTEEN_OR_PCI_RESET]) begin
            state_next.cfg[CFG_GP15_GPIO] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    state_next.status = (state_reg.status & ~clr_bits) | set_bits;
    state_next.rdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        ADDR_IER: state_next.rdata = {24'h00_0000, state_reg.interrupt_enable_bits};
        ADDR_POL: state_next.rdata = {28'h000_0000, state_reg.pol};
        ADDR_STATUS: state_next.rdata = {27'h000_0000, state_reg.status};
        ADDR_MASK: state_next.rdata = {27'h000_0000, state_reg.mask};
        ADDR_GPIO_DIR: state_next.rdata = {27'h000_0000, state_reg.dir};
        ADDR_GPIO_OUT: state_next.rdata = {27'h000_0000, state_reg.dout};
        ADDR_GPIO_IN: state_next.rdata = {27'h000_0000, state_reg.g15_sync, state_reg.pin_sync};
        ADDR_CONFIG: state_next.rdata = {30'h0000_0000, state_reg.cfg};
        ADDR_MODE: state_next.rdata = {30'h0000_0000, state_reg.mode_latched};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (!rst_n) begin
      state_next = '0;
      state_next.mode_latched = MODE_STRAP_DEFAULT;
      state_next.interrupt_enable_bits = IER_RESET;
      state_next.pol = POL_RESET;
      state_next.status = STATUS_RESET;
      state_next.mask = MASK_RESET;
      state_next.dir = DIR_RESET;
      state_next.dout = OUT_RESET;
      state_next.cfg = CFG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // Nonmaskable bit ignores its mask bit entirely
  assign irq = state_reg.status[ST_NMI]
      | (|(state_reg.status[NUM_EXT-1:0] & state_reg.mask[NUM_EXT-1:0]));
  assign nmi_pulse = state_reg.nmi_p;
  assign ext_irq_pulse = state_reg.ext_p;
  assign rdata = state_reg.rdata;
  // Interrupt-enabled pins never drive
  assign shared_pin_oe = state_reg.dir[NUM_EXT-1:0] & ~state_reg.interrupt_enable_bits[IER_HI:IER_LO];
  assign shared_pin_out = state_reg.dout[NUM_EXT-1:0];
  assign gpio_fifteen_or_pci_reset_oe = state_reg.cfg[CFG_GP15_GPIO]
      & state_reg.dir[GP15_BIT];
  assign gpio_fifteen_or_pci_reset_out = state_reg.dout[GP15_BIT];
  assign pci_reset_n = ~(state_reg.cfg[CFG_GPIO_FIFTEEN_OR_PCI_RESET] & ~state_reg.g15_sync);
  assign boundary_scan_mode = (op_mode == OP_BSCAN);
  assign emulation_mode = (op_mode == OP_EMU);
  assign mode_reserved = (op_mode == OP_RSVD_A) || (op_mode == OP_RSVD_B);
  // Core runs freely under either valid strap
  assign core_run_enable = boundary_scan_mode | emulation_mode;

  // Assertions
  nmi_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.nmi_sync && !state_reg.nmi_prev) |=> nmi_pulse && irq)
    else $error("nmi edge not raised");
  nmi_unmasked_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_pulse |-> irq)
    else $error("nmi masked");
  pins_input_a: assert property (@(posedge clk)
      !rst_n |=> (shared_pin_oe == '0) && !gpio_fifteen_or_pci_reset_oe)
    else $error("pin driven after reset");
  irq_pin_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg.interrupt_enable_bits[IER_LO] |-> !shared_pin_oe[0])
    else $error("interrupt pin driven");
  ext_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(state_reg.interrupt_enable_bits[IER_LO]) |-> !ext_irq_pulse[0])
    else $error("disabled pin interrupted");
  ext_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.interrupt_enable_bits[IER_LO] && !state_reg.pol[POL_LO] && !state_reg.dir[0]
       && state_reg.pin_sync[0] && !state_reg.pin_prev[0]) |=> ext_irq_pulse[0])
    else $error("rising edge missed");
  ext_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.pol[POL_LO] && state_reg.pin_sync[0] && !state_reg.pin_prev[0])
      |=> !ext_irq_pulse[0])
    else $error("wrong edge polarity");
  gp15_default_a: assert property (@(posedge clk)
      !rst_n |=> pci_reset_n && !gpio_fifteen_or_pci_reset_oe)
    else $error("pin 15 active by default");
  mode_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.mode_latched == MODE_BSCAN) |-> boundary_scan_mode && core_run_enable)
    else $error("mode decode wrong");

  // Strap decode and free running
  reserved_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_reserved |-> !core_run_enable)
    else $error("reserved mode runs");

  emu_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.mode_latched == MODE_EMU) |-> emulation_mode && core_run_enable)
    else $error("emulation decode wrong");

  mode_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot({boundary_scan_mode, emulation_mode, mode_reserved}))
    else $error("mode flags overlap");

  strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg.strap_taken |=> $stable(state_reg.mode_latched))
    else $error("strap changed after capture");

  run_free_a: assert property (@(posedge clk) disable iff (!rst_n)
      !mode_reserved |-> core_run_enable)
    else $error("core held under valid strap");

  strap_default_a: assert property (@(posedge clk)
      !rst_n |=> state_reg.mode_latched == MODE_STRAP_DEFAULT)
    else $error("strap default wrong");

  strap_early_a: assert property (@(posedge clk) disable iff (!rst_n)
      !state_reg.strap_taken |-> state_reg.mode_latched == MODE_STRAP_DEFAULT)
    else $error("strap latched early");

  // Nonmaskable interrupt
  nmi_status_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_pulse |-> state_reg.status[ST_NMI])
    else $error("nmi status missing");

  nmi_mask_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg.status[ST_NMI] |-> irq)
    else $error("nmi status without irq");

  nmi_only_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!state_reg.nmi_sync && state_reg.nmi_prev) |=> !nmi_pulse)
    else $error("nmi on falling edge");

  nmi_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_event |=> state_reg.status[ST_NMI])
    else $error("nmi lost to clear");

  nmi_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.status[ST_NMI] && !(wr_en && addr == ADDR_STATUS && wdata[ST_NMI]))
      |=> state_reg.status[ST_NMI])
    else $error("nmi status dropped");

  // External interrupts
  ext_status_a: assert property (@(posedge clk) disable iff (!rst_n)
      ext_irq_pulse[0] |-> state_reg.status[0])
    else $error("ext status missing");

  irq_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
      ((state_reg.status[NUM_EXT-1:0] & state_reg.mask[NUM_EXT-1:0]) == '0
       && !state_reg.status[ST_NMI]) |-> !irq)
    else $error("irq without unmasked cause");

  irq_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.status[1] && state_reg.mask[1]) |-> irq)
    else $error("unmasked ext irq missing");

  ext_dir_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg.dir[0] |=> !ext_irq_pulse[0])
    else $error("output pin interrupted");

  irq_pins_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (shared_pin_oe & state_reg.interrupt_enable_bits[IER_HI:IER_LO]) == '0)
    else $error("enabled pin driven");

  status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && addr == ADDR_STATUS && wdata[0] && !ext_event[0]) |=> !state_reg.status[0])
    else $error("status not cleared");

  ext_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      ext_event[0] |=> state_reg.status[0])
    else $error("ext event lost to clear");

  ext_fall_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.interrupt_enable_bits[IER_LO] && state_reg.pol[POL_LO] && !state_reg.dir[0]
       && !state_reg.pin_sync[0] && state_reg.pin_prev[0]) |=> ext_irq_pulse[0])
    else $error("falling edge missed");

  ext_rise_blocked_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!state_reg.pol[POL_LO] && !state_reg.pin_sync[0] && state_reg.pin_prev[0])
      |=> !ext_irq_pulse[0])
    else $error("falling edge under rising polarity");

  pol_independent_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.interrupt_enable_bits[IER_HI] && state_reg.pol[POL_HI] && !state_reg.dir[3]
       && !state_reg.pin_sync[3] && state_reg.pin_prev[3]) |=> ext_irq_pulse[3])
    else $error("top polarity bit ignored");

  // Reset state of the pins
  pins_reset_quiet_a: assert property (@(posedge clk)
      !rst_n |=> shared_pin_out == '0)
    else $error("pin output set after reset");

  ier_reset_a: assert property (@(posedge clk)
      !rst_n |=> state_reg.interrupt_enable_bits == IER_RESET && !irq)
    else $error("enables set after reset");

  // Pin 15 functions
  pci_reset_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg.cfg[CFG_GPIO_FIFTEEN_OR_PCI_RESET] && !state_reg.g15_sync) |-> !pci_reset_n)
    else $error("pci reset not passed");

  pci_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !state_reg.cfg[CFG_GPIO_FIFTEEN_OR_PCI_RESET] |-> pci_reset_n)
    else $error("pci reset outside its mode");

  gp15_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(state_reg.cfg[CFG_GP15_GPIO] && state_reg.cfg[CFG_GPIO_FIFTEEN_OR_PCI_RESET]))
    else $error("pin 15 in both modes");

  gp15_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      gpio_fifteen_or_pci_reset_oe |-> !state_reg.cfg[CFG_GPIO_FIFTEEN_OR_PCI_RESET])
    else $error("pin 15 driven as reset input");

endmodule : mode_pins_and_ext_interrupts

`default_nettype wire

// >>> irq_sources.sv
`timescale 1ns/1ps
`default_nettype none

module irq_sources (
  // Bench commands
  input wire logic clk,
  input wire logic [1:0] strap,
  input wire logic nmi_req,
  input wire logic [3:0] pins_req,
  // Board side
  output logic mode_select_bit_high,
  output logic mode_select_bit_low,
  output logic nmi_pin,
  output logic [3:0] shared_pin_in
);
  // Test reset is not modelled; it stays at its pull-down
  always_ff @(posedge clk) begin
    mode_select_bit_high <= strap[1];
    mode_select_bit_low <= strap[0];
    nmi_pin <= nmi_req; // Held solidly low between events
    shared_pin_in <= pins_req;
  end
endmodule : irq_sources

`default_nettype wire

// >>> mode_pins_and_ext_interrupts_test.sv
`timescale 1ns/1ps
`default_nettype none

module mode_pins_and_ext_interrupts_test;
  import pins_pkg::*;
  logic clk = 0, rst_n = 0, nmi_req = 0, wr_en = 0, rd_en = 0, p15_in = 1;
  logic [1:0] strap = 2'h3;
  logic [3:0] pins_req = 4'h0, addr = 4'h0, pol;
  logic [31:0] wdata = 32'h0, rd_val;
  logic mhi, mlo, nmi_pin, nmi_pulse, pci_reset_n, bs, emu, rsv, run, irq, p15_out, p15_oe;
  logic [3:0] sp_in, sp_out, sp_oe, ext_irq_pulse;
  int err_total = 0, checked = 0, seed = 45, n_nmi, n_ext[4];

  irq_sources src (.clk(clk), .strap(strap), .nmi_req(nmi_req), .pins_req(pins_req),
    .mode_select_bit_high(mhi), .mode_select_bit_low(mlo), .nmi_pin(nmi_pin),
    .shared_pin_in(sp_in));

  mode_pins_and_ext_interrupts DUT (.clk(clk), .rst_n(rst_n), .mode_select_bit_high(mhi),
    .mode_select_bit_low(mlo), .nmi_pin(nmi_pin), .shared_pin_in(sp_in),
    .shared_pin_out(sp_out), .shared_pin_oe(sp_oe), .gpio_fifteen_or_pci_reset_in(p15_in),
    .gpio_fifteen_or_pci_reset_out(p15_out), .gpio_fifteen_or_pci_reset_oe(p15_oe),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rd_val),
    .nmi_pulse(nmi_pulse), .ext_irq_pulse(ext_irq_pulse), .pci_reset_n(pci_reset_n),
    .boundary_scan_mode(bs), .emulation_mode(emu), .mode_reserved(rsv),
    .core_run_enable(run), .irq(irq));

  initial begin
    forever #4 clk = ~clk;
  end

  task finish_test;
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    #1 cmp(rd_val, exp);
  endtask : rd

  // Counts pulses over the next n cycles, sampled 1 ns after each rising edge, with no settling wait
  task run_cycles(input int n);
    n_nmi = 0;
    n_ext = '{0, 0, 0, 0};
    repeat (n) begin
      @(posedge clk);
      #1;
      if (nmi_pulse === 1'b1) n_nmi++;
      for (int i = 0; i < 4; i++) if (ext_irq_pulse[i] === 1'b1) n_ext[i]++;
    end
  endtask : run_cycles

  initial begin
    #400000;
    err_total++;
    finish_test;
  end

  initial begin
    for (int c = 0; c < 4; c++) begin
      strap <= c[1:0];
      rst_n <= 0;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      run_cycles(10);
      cmp({bs, emu, rsv}, {c == 0, c == 3, c == 1 || c == 2});
      cmp(run, c == 0 || c == 3);
      cmp({sp_oe, sp_out}, 8'h00);
      cmp({p15_oe, pci_reset_n}, 2'b01);
      rd(ADDR_MODE, c);
    end
    rd(4'hF, 32'h0);
    nmi_req <= 1;
    run_cycles(10);
    cmp(n_nmi, 1);
    cmp(irq, 1'b1);
    nmi_req <= 0;
    wr(ADDR_STATUS, 32'h10);
    run_cycles(4);
    cmp(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_IER, 32'h0);
      pol = 4'($random(seed));
      pins_req <= pol;
      wr(ADDR_POL, pol);
      pins_req[i] <= ~pol[i];
      run_cycles(8);
      cmp(n_ext[i], 0);
      pins_req <= pol;
      run_cycles(6);
      wr(ADDR_STATUS, 32'h1F);
      wr(ADDR_IER, 32'hF0);
      wr(ADDR_MASK, 32'h0F);
      run_cycles(6);
      pins_req[i] <= ~pol[i];
      run_cycles(8);
      for (int k = 0; k < 4; k++) cmp(n_ext[k], k == i);
      cmp({irq, sp_oe}, 5'h10);
      rd(ADDR_STATUS, 1 << i);
      wr(ADDR_MASK, 32'h0);
      #1 cmp(irq, 1'b0);
      wr(ADDR_STATUS, 1 << i);
      pins_req <= pol;
      run_cycles(8);
      cmp(n_ext[i], 0);
    end
    wr(ADDR_CONFIG, 32'h2);
    p15_in <= 0;
    run_cycles(6);
    cmp(pci_reset_n, 1'b0);
    wr(ADDR_CONFIG, 32'h3);
    rd(ADDR_CONFIG, 32'h2);
    wr(ADDR_CONFIG, 32'h1);
    wr(ADDR_GPIO_DIR, 32'h10);
    wr(ADDR_GPIO_OUT, 32'h10);
    run_cycles(3);
    cmp({p15_oe, p15_out, pci_reset_n}, 3'b111);
    finish_test;
  end
endmodule : mode_pins_and_ext_interrupts_test

`default_nettype wire
